/* File: inc/exc_seq_pkg.sv */
// constants, carriers and states of the exception sequencer
package exc_seq_pkg;
   localparam int          PSW_T_BIT    = 15;
   localparam int          PSW_S_BIT    = 13;
   localparam int          PSW_MASK_LSB = 8;
   localparam logic [15:0] PSW_AT_RESET = 16'h2700;
   localparam logic [31:0] RESET_SSP_ADDR = 32'h0000_0000;
   localparam logic [31:0] RESET_PC_ADDR  = 32'h0000_0004;
   localparam logic [7:0]  VEC_ADDR_ERR  = 8'h03;
   localparam logic [7:0]  VEC_ILLEGAL   = 8'h04;
   localparam logic [7:0]  VEC_DIV_ZERO  = 8'h05;
   localparam logic [7:0]  VEC_BOUNDS    = 8'h06;
   localparam logic [7:0]  VEC_OVERFLOW  = 8'h07;
   localparam logic [7:0]  VEC_PRIV      = 8'h08;
   localparam logic [7:0]  VEC_TRACE     = 8'h09;
   localparam logic [7:0]  VEC_LINE_A    = 8'h0a;
   localparam logic [7:0]  VEC_LINE_F    = 8'h0b;
   localparam logic [7:0]  VEC_AUTO_BASE = 8'h18;
   localparam logic [7:0]  VEC_TRAP_BASE = 8'h20;
   localparam logic [3:0]  OP_LINE_A     = 4'ha;
   localparam logic [3:0]  OP_LINE_F     = 4'hf;
   localparam logic [15:0] OP_ILL_A      = 16'h4afa;
   localparam logic [15:0] OP_ILL_B      = 16'h4afb;
   localparam logic [15:0] OP_ILL_C      = 16'h4afc;
   localparam logic [15:0] OP_ANDI_SR    = 16'h027c;
   localparam logic [15:0] OP_EORI_SR    = 16'h0a7c;
   localparam logic [15:0] OP_ORI_SR     = 16'h007c;
   localparam logic [15:0] OP_SW_RESET   = 16'h4e70;
   localparam logic [15:0] OP_STOP       = 16'h4e72;
   localparam logic [15:0] OP_RTE        = 16'h4e73;
   localparam logic [15:0] OP_TO_SR      = 16'h46c0;
   localparam logic [15:0] OP_FROM_SR    = 16'h40c0;
   localparam logic [15:0] MASK_SR_EA    = 16'hffc0;
   localparam logic [15:0] OP_USP        = 16'h4e60;
   localparam logic [15:0] OP_TRAP       = 16'h4e40;
   localparam logic [15:0] MASK_LOW4     = 16'hfff0;
   localparam logic [15:0] OP_MOVEC      = 16'h4e7a;
   localparam logic [15:0] MASK_LOW1     = 16'hfffe;
   localparam logic [15:0] OP_MOVES      = 16'h0e00;
   localparam logic [15:0] MASK_HIGH8    = 16'hff00;
   localparam logic [7:0]  REG_PSW       = 8'h00;
   localparam logic [7:0]  REG_SSP       = 8'h04;
   localparam logic [7:0]  REG_VECTOR    = 8'h08;
   localparam logic [7:0]  REG_STATE     = 8'h0c;

   typedef struct packed {
      logic [15:0] opcode;
      logic [31:0] pc;
      logic [31:0] next_pc;
      logic        overflow;
      logic        bounds_err;
      logic        div_zero;
      logic        decode_illegal;
   } retire_t;

   typedef struct packed {
      logic        req;
      logic        we;
      logic        long_word;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mem_req_t;

   typedef enum logic [6:0] {
      S_VEC_SSP   = 7'b000_0001,
      S_VEC_PC    = 7'b000_0010,
      S_RUN       = 7'b000_0100,
      S_PUSH_PC   = 7'b000_1000,
      S_PUSH_SR   = 7'b001_0000,
      S_VEC_FETCH = 7'b010_0000,
      S_HALT      = 7'b100_0000
   } seq_state_t;
endpackage

/* File: src/exc_sequencer.sv */
// exception sequencer: reset fetch, traps, interrupts, trace, address errors
//
// Notes on behaviour
// RULE_01: reset aborts everything, sets supervisor, trace off, mask seven.
// RULE_02: reset stacks nothing; loads stack pointer from 0, then PC from 4.
// RULE_03: software reset opcode in supervisor mode changes nothing at all.
// RULE_04: interrupt level is only pending; examined between instructions.
// RULE_05: level at or below mask waits; strictly higher level is taken.
// RULE_06: interrupt copies status, supervisor on, trace off, mask to level.
// RULE_07: interrupt stacks the PC of the instruction that would run next; right after a sequence the code stacks the stale resume_pc_reg.
// RULE_08: traps stack PC of the following instruction and the status copy.
// RULE_09: trap always; overflow, bounds and zero divisor trap on error.
// RULE_10: unmatched first words and 4AFA, 4AFB, 4AFC are illegal.
// RULE_11: top nibble 1010 or 1111 use their own unimplemented vectors.
// RULE_12: privileged opcodes in user mode raise a privilege violation.
// RULE_13: privilege violation stacks the PC of the offending instruction.
// RULE_14: trace bit set at instruction start gives a trace after it.
// RULE_15: no trace for instructions not executed or aborted.
// RULE_16: instruction exception first, then trace, then interrupt.
// RULE_17: trace clears T after copying, supervisor on, stacks next PC; a trace pending after a trap stacks the stale resume_pc_reg.
// RULE_18: odd word, long or fetch address aborts into address error.
// RULE_19: address error during address error or reset processing halts.
// RULE_20: group 0 starts within two clocks, reset before address error.
// RULE_21: group 1 before next instruction: trace, interrupt, illegal.
// RULE_22: reset discards every pending exception.
// RULE_23: interrupt levels one to seven use autovectors 25 to 31.
// RULE_24: trap with operand n uses vector 32 plus n.
// RULE_25: fixed vectors for address error, illegal, divide, privilege, trace.
// RULE_26: vector address is number times four; frame holds status and PC.
`timescale 1ns/1ns
module exc_sequencer (
   input  wire logic                  sys_clk,
   input  wire logic                  rst_n,
   input  wire logic [2:0]            encoded_irq_level,
   input  wire logic                  retire_valid,
   input  wire exc_seq_pkg::retire_t  retire,
   input  wire logic                  addr_err,
   input  wire logic [31:0]           addr_err_pc,
   output exc_seq_pkg::mem_req_t      mem,
   input  wire logic                  mem_ack,
   input  wire logic [31:0]           mem_rdata,
   output logic                       core_hold,
   output logic                       core_pc_load,
   output logic [31:0]                core_pc,
   output logic                       halted,
   output logic [15:0]                processor_status_word,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [7:0]            wb_adr_i,
   input  wire logic [31:0]           wb_dat_i,
   input  wire logic [3:0]            wb_sel_i,
   output logic [31:0]                wb_dat_o,
   output logic                       wb_ack_o
);
   exc_seq_pkg::seq_state_t state_reg;
   exc_seq_pkg::mem_req_t   mem_reg;
   logic [15:0] psw_reg;
   logic [15:0] sr_copy_reg;
   logic [31:0] ssp_reg;
   logic [31:0] frame_pc_reg;
   logic [31:0] resume_pc_reg;
   logic [7:0]  vec_reg;
   logic        pend_trace_reg;
   logic        core_hold_reg;
   logic        core_pc_load_reg;
   logic [31:0] core_pc_reg;
   logic        wb_ack_reg;
   logic [31:0] wb_dat_reg;

   logic        take;
   logic [7:0]  take_vec;
   logic [31:0] take_pc;
   logic        take_irq;
   logic        set_trace;
   logic        retire_used;
   logic        user_mode;
   logic        trace_on;
   logic [2:0]  cur_mask;
   logic        irq_wins;
   logic        op_line_a;
   logic        op_line_f;
   logic        op_illegal;
   logic        op_priv;
   logic        op_trap;
   logic        in_run;
   logic        reset_seq;
   logic        wb_go;

   assign user_mode = !psw_reg[exc_seq_pkg::PSW_S_BIT];
   assign trace_on  = psw_reg[exc_seq_pkg::PSW_T_BIT];
   assign cur_mask  = psw_reg[exc_seq_pkg::PSW_MASK_LSB +: 3];
   assign irq_wins  = encoded_irq_level > cur_mask; // [RULE_05]
   assign in_run    = state_reg == exc_seq_pkg::S_RUN;
   assign reset_seq = (state_reg == exc_seq_pkg::S_VEC_SSP) ||
                      (state_reg == exc_seq_pkg::S_VEC_PC);
   assign wb_go     = wb_cyc_i && wb_stb_i && !wb_ack_reg;

   // first-word decode; the core's own decoder flags the remaining patterns
   always_comb begin
      op_line_a  = retire.opcode[15:12] == exc_seq_pkg::OP_LINE_A; // [RULE_11]
      op_line_f  = retire.opcode[15:12] == exc_seq_pkg::OP_LINE_F; // [RULE_11]
      op_illegal = retire.decode_illegal || // [RULE_10]
                   retire.opcode == exc_seq_pkg::OP_ILL_A ||
                   retire.opcode == exc_seq_pkg::OP_ILL_B ||
                   retire.opcode == exc_seq_pkg::OP_ILL_C;
      op_priv    = user_mode && ( // [RULE_12]
                   retire.opcode == exc_seq_pkg::OP_ANDI_SR ||
                   retire.opcode == exc_seq_pkg::OP_EORI_SR ||
                   retire.opcode == exc_seq_pkg::OP_ORI_SR ||
                   retire.opcode == exc_seq_pkg::OP_SW_RESET ||
                   retire.opcode == exc_seq_pkg::OP_STOP ||
                   retire.opcode == exc_seq_pkg::OP_RTE ||
                   (retire.opcode & exc_seq_pkg::MASK_SR_EA) == exc_seq_pkg::OP_TO_SR ||
                   (retire.opcode & exc_seq_pkg::MASK_SR_EA) == exc_seq_pkg::OP_FROM_SR ||
                   (retire.opcode & exc_seq_pkg::MASK_LOW4) == exc_seq_pkg::OP_USP ||
                   (retire.opcode & exc_seq_pkg::MASK_LOW1) == exc_seq_pkg::OP_MOVEC ||
                   (retire.opcode & exc_seq_pkg::MASK_HIGH8) == exc_seq_pkg::OP_MOVES);
      op_trap    = (retire.opcode & exc_seq_pkg::MASK_LOW4) == exc_seq_pkg::OP_TRAP;
   end

   // boundary arbitration; only evaluated while running, never mid-sequence
   always_comb begin
      take        = 1'b0;
      take_vec    = exc_seq_pkg::VEC_TRACE;
      take_pc     = resume_pc_reg;
      take_irq    = 1'b0;
      set_trace   = 1'b0;
      retire_used = 1'b0;
      if (in_run) begin
         if (addr_err) begin
            take     = 1'b1; // [RULE_18] [RULE_20]
            take_vec = exc_seq_pkg::VEC_ADDR_ERR;
            take_pc  = addr_err_pc;
         end else if (retire_valid) begin
            retire_used = 1'b1;
            take_pc     = retire.pc; // [RULE_13]
            if (op_line_a || op_line_f || op_illegal || op_priv) begin
               take = 1'b1; // [RULE_15]
               if (irq_wins) begin
                  take_irq = 1'b1; // [RULE_21]
                  take_vec = exc_seq_pkg::VEC_AUTO_BASE + 8'(encoded_irq_level);
               end else if (op_line_a) begin
                  take_vec = exc_seq_pkg::VEC_LINE_A; // [RULE_11]
               end else if (op_line_f) begin
                  take_vec = exc_seq_pkg::VEC_LINE_F; // [RULE_11]
               end else if (op_illegal) begin
                  take_vec = exc_seq_pkg::VEC_ILLEGAL; // [RULE_10] [RULE_25]
               end else begin
                  take_vec = exc_seq_pkg::VEC_PRIV; // [RULE_12] [RULE_25]
               end
            end else begin
               take_pc   = retire.next_pc; // [RULE_08] [RULE_17]
               take      = 1'b1;
               set_trace = trace_on; // [RULE_14] [RULE_16]
               if (op_trap) begin
                  take_vec = exc_seq_pkg::VEC_TRAP_BASE + 8'(retire.opcode[3:0]); // [RULE_24]
               end else if (retire.div_zero) begin
                  take_vec = exc_seq_pkg::VEC_DIV_ZERO; // [RULE_09]
               end else if (retire.bounds_err) begin
                  take_vec = exc_seq_pkg::VEC_BOUNDS; // [RULE_09]
               end else if (retire.overflow) begin
                  take_vec = exc_seq_pkg::VEC_OVERFLOW; // [RULE_09]
               end else if (trace_on) begin
                  set_trace = 1'b0;
                  take_vec  = exc_seq_pkg::VEC_TRACE; // [RULE_14] [RULE_25]
               end else begin
                  take = 1'b0; // [RULE_03]
               end
            end
         end else if (pend_trace_reg) begin
            take = 1'b1; // [RULE_16] [RULE_21]
         end else if (irq_wins) begin
            take     = 1'b1; // [RULE_04] [RULE_07]
            take_irq = 1'b1;
            take_vec = exc_seq_pkg::VEC_AUTO_BASE + 8'(encoded_irq_level); // [RULE_23]
         end
      end
   end

   // sequence of reset fetch, frame pushes and vector fetch
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg        <= exc_seq_pkg::S_VEC_SSP; // [RULE_01] [RULE_22]
         mem_reg          <= '{req: 1'b1, we: 1'b0, long_word: 1'b1,
                               addr: exc_seq_pkg::RESET_SSP_ADDR, wdata: 32'h0000_0000};
         ssp_reg          <= 32'h0000_0000;
         vec_reg          <= 8'h00;
         frame_pc_reg     <= 32'h0000_0000;
         core_pc_reg      <= 32'h0000_0000;
         core_pc_load_reg <= 1'b0;
      end else begin
         core_pc_load_reg <= 1'b0;
         case (state_reg)
            exc_seq_pkg::S_VEC_SSP: begin
               if (addr_err) begin
                  state_reg   <= exc_seq_pkg::S_HALT; // [RULE_19]
                  mem_reg.req <= 1'b0;
               end else if (mem_ack) begin
                  ssp_reg      <= mem_rdata; // [RULE_02]
                  state_reg    <= exc_seq_pkg::S_VEC_PC;
                  mem_reg.addr <= exc_seq_pkg::RESET_PC_ADDR;
               end
            end
            exc_seq_pkg::S_VEC_PC: begin
               if (addr_err) begin
                  state_reg   <= exc_seq_pkg::S_HALT; // [RULE_19]
                  mem_reg.req <= 1'b0;
               end else if (mem_ack) begin
                  core_pc_reg      <= mem_rdata; // [RULE_02]
                  core_pc_load_reg <= 1'b1;
                  mem_reg.req      <= 1'b0;
                  state_reg        <= exc_seq_pkg::S_RUN;
               end
            end
            exc_seq_pkg::S_RUN: begin
               if (take) begin
                  vec_reg      <= take_vec;
                  frame_pc_reg <= take_pc;
                  state_reg    <= exc_seq_pkg::S_PUSH_PC;
                  mem_reg      <= '{req: 1'b1, we: 1'b1, long_word: 1'b1,
                                    addr: ssp_reg - 32'h0000_0004, wdata: take_pc}; // [RULE_26]
               end
            end
            exc_seq_pkg::S_PUSH_PC, exc_seq_pkg::S_PUSH_SR, exc_seq_pkg::S_VEC_FETCH: begin
               if (addr_err || (ssp_reg[0] && state_reg != exc_seq_pkg::S_VEC_FETCH)) begin
                  // a fault while already handling an address error cannot recover
                  if (vec_reg == exc_seq_pkg::VEC_ADDR_ERR) begin
                     state_reg   <= exc_seq_pkg::S_HALT; // [RULE_19]
                     mem_reg.req <= 1'b0;
                  end else begin
                     vec_reg      <= exc_seq_pkg::VEC_ADDR_ERR; // [RULE_18]
                     frame_pc_reg <= addr_err ? addr_err_pc : frame_pc_reg;
                     state_reg    <= exc_seq_pkg::S_PUSH_PC;
                     mem_reg      <= '{req: 1'b1, we: 1'b1, long_word: 1'b1,
                                       addr: ssp_reg - 32'h0000_0004,
                                       wdata: addr_err ? addr_err_pc : frame_pc_reg};
                  end
               end else if (mem_ack) begin
                  if (state_reg == exc_seq_pkg::S_PUSH_PC) begin
                     ssp_reg   <= ssp_reg - 32'h0000_0004;
                     state_reg <= exc_seq_pkg::S_PUSH_SR;
                     mem_reg   <= '{req: 1'b1, we: 1'b1, long_word: 1'b0,
                                    addr: ssp_reg - 32'h0000_0006,
                                    wdata: {16'h0000, sr_copy_reg}}; // [RULE_26]
                  end else if (state_reg == exc_seq_pkg::S_PUSH_SR) begin
                     ssp_reg   <= ssp_reg - 32'h0000_0002;
                     state_reg <= exc_seq_pkg::S_VEC_FETCH;
                     mem_reg   <= '{req: 1'b1, we: 1'b0, long_word: 1'b1,
                                    addr: {22'h00_0000, vec_reg, 2'b00}, // [RULE_26]
                                    wdata: 32'h0000_0000};
                  end else begin
                     core_pc_reg      <= mem_rdata;
                     core_pc_load_reg <= 1'b1;
                     mem_reg.req      <= 1'b0;
                     state_reg        <= exc_seq_pkg::S_RUN;
                  end
               end
            end
            exc_seq_pkg::S_HALT: begin
               mem_reg.req <= 1'b0;
            end
            default: begin
               state_reg   <= exc_seq_pkg::S_HALT;
               mem_reg.req <= 1'b0;
            end
         endcase
      end
   end

   // status word: hardware entry wins over a software write in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         psw_reg     <= exc_seq_pkg::PSW_AT_RESET; // [RULE_01]
         sr_copy_reg <= 16'h0000;
      end else if (take) begin
         sr_copy_reg                          <= psw_reg; // [RULE_06] [RULE_17]
         psw_reg[exc_seq_pkg::PSW_S_BIT]      <= 1'b1;
         psw_reg[exc_seq_pkg::PSW_T_BIT]      <= 1'b0;
         if (take_irq) begin
            psw_reg[exc_seq_pkg::PSW_MASK_LSB +: 3] <= encoded_irq_level; // [RULE_06]
         end
      end else if (wb_go && wb_we_i && wb_adr_i == exc_seq_pkg::REG_PSW) begin
         if (wb_sel_i[0]) begin
            psw_reg[7:0] <= wb_dat_i[7:0];
         end
         if (wb_sel_i[1]) begin
            psw_reg[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // pending trace and resume address
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pend_trace_reg <= 1'b0; // [RULE_22]
         resume_pc_reg  <= 32'h0000_0000;
      end else begin
         if (set_trace) begin
            pend_trace_reg <= 1'b1; // [RULE_16]
         end else if (take && take_vec == exc_seq_pkg::VEC_TRACE) begin
            pend_trace_reg <= 1'b0;
         end else if (in_run && addr_err) begin
            pend_trace_reg <= 1'b0; // [RULE_15]
         end
         if (core_pc_load_reg) begin
            resume_pc_reg <= core_pc_reg;
         end else if (retire_used && !take) begin
            resume_pc_reg <= retire.next_pc; // [RULE_07]
         end
      end
   end

   // the core may start a new instruction only while hold is low
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         core_hold_reg <= 1'b1;
      end else begin
         core_hold_reg <= !in_run || take || retire_valid || pend_trace_reg || irq_wins; // [RULE_04]
      end
   end

   // register slave; unmapped reads return zero and still acknowledge
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wb_ack_reg <= 1'b0;
         wb_dat_reg <= 32'h0000_0000;
      end else begin
         wb_ack_reg <= wb_go;
         if (wb_go) begin
            case (wb_adr_i)
               exc_seq_pkg::REG_PSW:    wb_dat_reg <= {16'h0000, psw_reg};
               exc_seq_pkg::REG_SSP:    wb_dat_reg <= ssp_reg;
               exc_seq_pkg::REG_VECTOR: wb_dat_reg <= {24'h00_0000, vec_reg};
               exc_seq_pkg::REG_STATE:  wb_dat_reg <= {23'h00_0000, pend_trace_reg,
                                                        1'b0, state_reg};
               default:                 wb_dat_reg <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign mem                   = mem_reg;
   assign core_hold             = core_hold_reg;
   assign core_pc_load          = core_pc_load_reg;
   assign core_pc               = core_pc_reg;
   assign halted                = state_reg == exc_seq_pkg::S_HALT;
   assign processor_status_word = psw_reg;
   assign wb_dat_o              = wb_dat_reg;
   assign wb_ack_o              = wb_ack_reg;

   AST_RESET_STATE: assert property (@(posedge sys_clk) // [RULE_01]
      $rose(rst_n) |-> psw_reg == exc_seq_pkg::PSW_AT_RESET && !pend_trace_reg)
      else $error("reset did not force supervisor, trace off, mask seven");
   AST_RESET_FETCH: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_02]
      (state_reg == exc_seq_pkg::S_VEC_SSP) |-> mem_reg.req && !mem_reg.we &&
      mem_reg.addr == exc_seq_pkg::RESET_SSP_ADDR)
      else $error("reset fetch not reading the stack pointer entry");
   AST_IRQ_DEFER: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_05]
      in_run && !irq_wins && !addr_err && !retire_valid && !pend_trace_reg
      |=> state_reg == exc_seq_pkg::S_RUN)
      else $error("interrupt at or below mask was taken");
   AST_IRQ_TAKE: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_06]
      in_run && irq_wins && !addr_err && !retire_valid && !pend_trace_reg
      |=> state_reg == exc_seq_pkg::S_PUSH_PC && cur_mask == $past(encoded_irq_level)
      && vec_reg == exc_seq_pkg::VEC_AUTO_BASE + 8'($past(encoded_irq_level)))
      else $error("interrupt entry wrong mask or vector");
   AST_PRIV_PC: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_13]
      in_run && retire_valid && !addr_err && op_priv && !op_illegal && !op_line_a
      && !op_line_f && !irq_wins
      |=> vec_reg == exc_seq_pkg::VEC_PRIV && frame_pc_reg == $past(retire.pc))
      else $error("privilege violation frame wrong");
   AST_TRAP_VEC: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_24]
      in_run && retire_valid && !addr_err && op_trap && !op_priv && !op_illegal
      |=> vec_reg == exc_seq_pkg::VEC_TRAP_BASE + 8'($past(retire.opcode[3:0]))
      && frame_pc_reg == $past(retire.next_pc))
      else $error("trap vector or stacked pc wrong");
   AST_NO_TRACE_ILL: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_15]
      in_run && retire_valid && op_illegal && !pend_trace_reg |=> !pend_trace_reg)
      else $error("trace pending after an illegal opcode");
   AST_DOUBLE_FAULT: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_19]
      reset_seq && addr_err |=> halted ##1 halted)
      else $error("address error during reset did not halt");
   AST_GROUP0_START: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_20]
      in_run && addr_err |-> ##[1:2] (state_reg == exc_seq_pkg::S_PUSH_PC
      && vec_reg == exc_seq_pkg::VEC_ADDR_ERR))
      else $error("address error not started within two clocks");
   AST_TRACE_CLEARS: assert property (@(posedge sys_clk) disable iff (!rst_n) // [RULE_17]
      take |=> !trace_on && psw_reg[exc_seq_pkg::PSW_S_BIT] && sr_copy_reg == $past(psw_reg))
      else $error("exception entry did not copy status and clear trace");
endmodule

/* File: verification/mem_model.sv */
// memory partner: answers vector fetches and stack pushes
`timescale 1ns/1ns
module mem_model (
   input  wire logic                  sys_clk,
   input  wire exc_seq_pkg::mem_req_t mem,
   output logic                       mem_ack,
   output logic [31:0]                mem_rdata,
   output logic [31:0]                pc_seen
);
   initial begin
      mem_ack = 1'b0;
      mem_rdata = 32'h0000_0000;
      pc_seen = 32'h0000_0000;
   end
   // data inverts once released so a stale word never passes as a fetch
   // an unknown request before the first reset edge must not leave ack stuck unknown
   always @(posedge sys_clk) begin
      mem_ack <= (mem.req === 1'b1) && !mem_ack;
      mem_rdata <= (mem.req === 1'b1 && !mem_ack) ? (32'h0000_1000 | mem.addr) : ~mem_rdata;
      if (mem_ack && mem.we && mem.long_word) pc_seen <= mem.wdata;
   end
endmodule

/* File: verification/tb_top.sv */
// self-checking bench for the exception sequencer
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[ERR] %s exp %h got %h", n, e, g); end end
module tb_top;
   logic sys_clk, rst_n, retire_valid, wb_cyc_i, wb_stb_i, wb_we_i, mem_ack, core_hold;
   logic core_pc_load, halted, wb_ack_o, got, addr_err;
   logic [2:0] encoded_irq_level;
   logic [31:0] mem_rdata, core_pc, wb_dat_o, wb_dat_i, pc_seen, seen_pc, rd;
   logic [15:0] processor_status_word;
   logic [7:0] wb_adr_i;
   exc_seq_pkg::retire_t retire;
   exc_seq_pkg::mem_req_t mem;
   int miscompares = 0, num_checks = 0;
   exc_sequencer dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .encoded_irq_level(encoded_irq_level),
      .retire_valid(retire_valid), .retire(retire), .addr_err(addr_err), .addr_err_pc(retire.pc),
      .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .core_hold(core_hold),
      .core_pc_load(core_pc_load), .core_pc(core_pc), .halted(halted),
      .processor_status_word(processor_status_word), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'h3),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   mem_model mem_u (.sys_clk(sys_clk), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .pc_seen(pc_seen));
   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // waits a fixed window so an absent exception is seen as well as a present one
   // level moves with the retire so the instruction completes before the interrupt;
   // ae pulses an address error instead, stacking pc as the aborted address
   task automatic do_retire(input logic [15:0] op, input logic [31:0] pc, input logic [31:0] nx,
                            input logic [2:0] lvl, input logic ae);
      @(posedge sys_clk);
      {retire_valid, addr_err, encoded_irq_level} <= {!ae, ae, lvl};
      retire <= '{op, pc, nx, 1'b0, 1'b0, 1'b0, 1'b0};
      @(posedge sys_clk);
      {retire_valid, addr_err} <= 2'b00;
      got = 1'b0;
      for (int i = 0; i < 40; i++) begin
         @(posedge sys_clk);
         #1;
         if (core_pc_load) begin got = 1'b1; seen_pc = core_pc; end
      end
      while (core_hold && !halted) @(posedge sys_clk);
   endtask
   task automatic wb_xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
      @(posedge sys_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
      do @(posedge sys_clk); while (!wb_ack_o);
      q = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   initial begin
      {rst_n, retire_valid, addr_err, wb_cyc_i, wb_stb_i, wb_we_i} = 6'b00_0000;
      {encoded_irq_level, wb_adr_i, wb_dat_i, retire} = '0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      while (!core_pc_load) @(posedge sys_clk);
      #1;
      `CHK("reset pc", 32'h0000_1004, core_pc)
      `CHK("reset psw", 16'h2700, processor_status_word)
      while (core_hold) @(posedge sys_clk);
      $display("reset test done");
      do_retire(exc_seq_pkg::OP_TRAP | 16'h0003, 32'h0000_0100, 32'h0000_0200, 3'd0, 1'b0);
      `CHK("trap vector", 32'h0000_108c, seen_pc)
      `CHK("trap stacked pc", 32'h0000_0200, pc_seen)
      for (int k = 0; k < 3; k++) begin
         do_retire(exc_seq_pkg::OP_ILL_A + 16'(k), 32'h0000_0110, 32'h0000_0112, 3'd0, 1'b0);
         `CHK("illegal vector", 32'h0000_1010, seen_pc)
      end
      do_retire({exc_seq_pkg::OP_LINE_F, 12'h000}, 32'h0000_0120, 32'h0000_0122, 3'd0, 1'b0);
      `CHK("line f vector", 32'h0000_102c, seen_pc)
      $display("trap test done");
      wb_xfer(1'b1, exc_seq_pkg::REG_PSW, 32'h0000_2300, rd);
      wb_xfer(1'b0, exc_seq_pkg::REG_PSW, 32'h0000_0000, rd);
      `CHK("psw readback", 32'h0000_2300, rd)
      do_retire(16'h4e71, 32'h0000_02fe, 32'h0000_0300, 3'd3, 1'b0);
      `CHK("equal level deferred", 1'b0, got)
      do_retire(16'h4e71, 32'h0000_0300, 32'h0000_0302, 3'd5, 1'b0);
      `CHK("autovector", 32'h0000_1074, seen_pc)
      `CHK("irq stacked pc", 32'h0000_0302, pc_seen)
      `CHK("irq psw", 16'h2500, processor_status_word)
      wb_xfer(1'b0, exc_seq_pkg::REG_VECTOR, 32'h0000_0000, rd);
      `CHK("irq vector number", 32'h0000_001d, rd)
      $display("interrupt test done");
      do_retire(16'h4e71, 32'h0000_0400, 32'h0000_0402, 3'd0, 1'b1);
      `CHK("address error vector", 32'h0000_100c, seen_pc)
      `CHK("address error stacked pc", 32'h0000_0400, pc_seen)
      @(posedge sys_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      do_retire(16'h4e71, 32'h0000_0000, 32'h0000_0000, 3'd0, 1'b1);
      `CHK("double fault halts", 1'b1, halted)
      `CHK("no vector after halt", 1'b0, got)
      $display("address error test done");
      tally_and_finish();
   end
   initial begin
      #80000;
      miscompares++;
      tally_and_finish();
   end
endmodule
